// *** msl_dev.sv ***
/*
 * monitor-mode command interpreter, device end of the serial link.
 * assumes rst is power-on reset, warm_rst a synchronous other reset.
 */
module msl_dev #(
	parameter int MEM_AW  = 16,
	parameter int BIT_DIV = msl_pkg::BIT_DIV
) (
	// clock and reset
	input  wire logic        sys_clk,
	input  wire logic        rst,
	input  wire logic        warm_rst,
	// link
	msl_link_if.dev          link,
	// entry straps and erase
	input  wire logic        test_high_voltage,
	input  wire logic        clock_divide_select_pin,
	input  wire logic        mass_erase,
	// status and run
	output logic             sec_ok,
	output logic             run_go,
	output logic [15:0]      run_pc,
	output logic [7:0]       index_hi,
	output logic             illegal_addr_rst
);
	typedef enum logic [3:0] {
		S_INIT, S_SEC, S_SECB, S_OP, S_ARG, S_WIN, S_EXEC, S_RET, S_BRK, S_RUN
	} msl_dev_st_e;

	typedef struct packed {
		msl_dev_st_e st;
		logic [2:0]  sync;
		logic [5:0]  strap;
		logic        rxv;
		logic        rxv_d;
		logic        rx_on;
		logic [3:0]  rx_n;
		logic [11:0] rx_t;
		logic [9:0]  rx_sh;
		logic        tx_on;
		logic [3:0]  tx_n;
		logic [11:0] tx_t;
		logic [11:0] tx_sh;
		logic        pin_o;
		logic        pin_oe;
		logic [11:0] bit_cyc;
		logic [3:0]  wcnt;
		logic [11:0] wt;
		logic [2:0]  sec_n;
		logic        sec_bad;
		logic        sec_ok;
		logic [63:0] code;
		logic [7:0]  op;
		logic [1:0]  argn;
		logic [23:0] arg;
		logic [15:0] ptr;
		logic [15:0] sp;
		logic [15:0] ret;
		logic [1:0]  retn;
		logic [7:0]  idx_hi;
		logic        run_go;
		logic [15:0] run_pc;
		logic        ill_rst;
	} msl_dev_s;

	msl_dev_s s_reg;
	msl_dev_s s_next;
	logic [7:0]        mem [0:(1 << MEM_AW) - 1];
	logic              mem_we;
	logic [15:0]       mem_a;
	logic [7:0]        mem_d;
	logic              rx_byte;
	logic              rx_brk;
	logic [7:0]        rxd;
	logic              tx_req;
	logic              tx_brk;
	logic [7:0]        tx_d;

	// flash hidden while locked
	function automatic logic [7:0] rd_byte(input logic [15:0] a, input logic [7:0] d, input logic ok);
		rd_byte = (a >= msl_pkg::FLASH_BASE && !ok) ? msl_pkg::INVALID_DATA : d;
	endfunction : rd_byte

	// operand count, top bit flags a known opcode
	function automatic logic [2:0] cmd_args(input logic [7:0] op);
		case (op)
			msl_pkg::CMD_READ:   cmd_args = 3'h6;
			msl_pkg::CMD_WRITE:  cmd_args = 3'h7;
			msl_pkg::CMD_INDEXED_WRITE_CMD: cmd_args = 3'h5;
			msl_pkg::CMD_INDEXED_READ_CMD,
			msl_pkg::CMD_SPREAD,
			msl_pkg::CMD_RUN:    cmd_args = 3'h4;
			default:             cmd_args = 3'h0;
		endcase
	endfunction : cmd_args

	// ****************
	// next state
	// ****************
	always_comb begin
		s_next = s_reg;
		s_next.run_go = 1'b0;
		s_next.ill_rst = 1'b0;
		mem_we = 1'b0;
		mem_a = '0;
		mem_d = '0;
		tx_req = 1'b0;
		tx_brk = 1'b0;
		tx_d = '0;
		rx_byte = 1'b0;
		rx_brk = 1'b0;

		// receiver
		s_next.sync = {s_reg.sync[1:0], link.line};
		s_next.strap = {s_reg.strap[3:0], test_high_voltage, clock_divide_select_pin};
		if (s_reg.sync[1] == s_reg.sync[2])
			s_next.rxv = s_reg.sync[2];
		s_next.rxv_d = s_reg.rxv;
		if (s_reg.tx_on) begin
			s_next.rx_on = 1'b0;
		end else if (!s_reg.rx_on) begin
			if (s_reg.rxv_d && !s_reg.rxv) begin
				s_next.rx_on = 1'b1;
				s_next.rx_n = '0;
				s_next.rx_t = s_reg.bit_cyc >> 1;
			end
		end else if (s_reg.rx_t == '0) begin
			s_next.rx_t = s_reg.bit_cyc - 12'h001;
			s_next.rx_n = s_reg.rx_n + 4'h1;
			if (s_reg.rx_n == 4'(msl_pkg::FRAME_BITS)) begin
				// reported after the full stop bit, once the sender has let go
				s_next.rx_on = 1'b0;
				rx_byte = s_reg.rx_sh[9];
				rx_brk = s_reg.rx_sh == '0;
			end else begin
				s_next.rx_sh = {s_reg.rxv, s_reg.rx_sh[9:1]};
				if (s_reg.rx_n == 4'(msl_pkg::FRAME_BITS - 1))
					s_next.rx_t = s_reg.bit_cyc >> 1;
			end
		end else begin
			s_next.rx_t = s_reg.rx_t - 12'h001;
		end
		rxd = s_next.rx_sh[8:1];

		// command sequencer
		case (s_reg.st)
			S_INIT: begin
				s_next.wt = s_reg.wt + 12'h001;
				if (s_reg.wt == 12'(msl_pkg::STRAP_WAIT)) begin
					s_next.wt = '0;
					s_next.st = S_SEC;
					if (s_reg.strap[5])
						s_next.bit_cyc = 12'(BIT_DIV * (s_reg.strap[4] ? msl_pkg::DIV_NORM_HI
							: msl_pkg::DIV_NORM_LO));
				end
			end
			S_SEC: if (rx_byte) begin
				tx_req = 1'b1;
				tx_d = rxd;
				if (rxd != s_reg.code[8 * (7 - s_reg.sec_n) +: 8])
					s_next.sec_bad = 1'b1;
				s_next.sec_n = s_reg.sec_n + 3'h1;
				if (s_reg.sec_n == 3'(msl_pkg::SEC_BYTES - 1))
					s_next.st = S_SECB;
			end
			S_SECB: if (!s_reg.tx_on) begin
				tx_req = 1'b1;
				tx_brk = 1'b1;
				s_next.st = S_OP;
				if (!s_reg.sec_bad) begin
					s_next.sec_ok = 1'b1;
					mem_we = 1'b1;
					mem_a = msl_pkg::RAM_STAT_ADDR;
					mem_d = 8'(1 << msl_pkg::RAM_STAT_BIT);
				end
			end
			S_OP: if (rx_brk) begin
				s_next.st = S_BRK;
			end else if (rx_byte) begin
				tx_req = 1'b1;
				tx_d = rxd;
				s_next.op = rxd;
				s_next.argn = cmd_args(rxd)[1:0];
				if (cmd_args(rxd)[2])
					s_next.st = (cmd_args(rxd)[1:0] == 2'h0) ? S_WIN : S_ARG;
				s_next.wcnt = '0;
				s_next.wt = s_reg.bit_cyc - 12'h001;
			end
			S_ARG: if (rx_brk) begin
				s_next.st = S_BRK;
			end else if (rx_byte) begin
				tx_req = 1'b1;
				tx_d = rxd;
				s_next.arg = {s_reg.arg[15:0], rxd};
				s_next.argn = s_reg.argn - 2'h1;
				if (s_reg.argn == 2'h1)
					s_next.st = S_WIN;
			end
			S_WIN: if (rx_brk) begin
				s_next.st = S_BRK;
			end else if (s_reg.tx_on) begin
				s_next.wt = s_reg.bit_cyc - 12'h001;
				s_next.wcnt = '0;
			end else if (s_reg.wt == '0) begin
				s_next.wt = s_reg.bit_cyc - 12'h001;
				s_next.wcnt = s_reg.wcnt + 4'h1;
				if (s_reg.wcnt == 4'(msl_pkg::WIN_BITS - 1))
					s_next.st = S_EXEC;
			end else begin
				s_next.wt = s_reg.wt - 12'h001;
			end
			S_EXEC: begin
				s_next.st = S_OP;
				case (s_reg.op)
					msl_pkg::CMD_READ: begin
						s_next.ret = {rd_byte(s_reg.arg[15:0], mem[s_reg.arg[MEM_AW-1:0]], s_reg.sec_ok), 8'h00};
						s_next.retn = 2'h1;
						s_next.ptr = s_reg.arg[15:0] + 16'h0001;
						s_next.st = S_RET;
					end
					msl_pkg::CMD_WRITE: begin
						mem_we = 1'b1;
						mem_a = s_reg.arg[23:8];
						mem_d = s_reg.arg[7:0];
						s_next.ptr = s_reg.arg[23:8] + 16'h0001;
					end
					msl_pkg::CMD_INDEXED_READ_CMD: begin
						s_next.ret = {rd_byte(s_reg.ptr, mem[s_reg.ptr[MEM_AW-1:0]], s_reg.sec_ok), 8'h00};
						s_next.retn = 2'h1;
						s_next.ptr = s_reg.ptr + 16'h0001;
						s_next.st = S_RET;
					end
					msl_pkg::CMD_INDEXED_WRITE_CMD: begin
						mem_we = 1'b1;
						mem_a = s_reg.ptr;
						mem_d = s_reg.arg[7:0];
						s_next.ptr = s_reg.ptr + 16'h0001;
					end
					msl_pkg::CMD_SPREAD: begin
						s_next.ret = s_reg.sp + 16'h0001;
						s_next.retn = 2'h2;
						s_next.st = S_RET;
					end
					default: begin
						s_next.idx_hi = mem[16'(s_reg.sp + 16'h0001)];
						s_next.run_pc = {mem[16'(s_reg.sp + msl_pkg::PC_HI_OFS)],
							mem[16'(s_reg.sp + msl_pkg::PC_LO_OFS)]};
						s_next.sp = s_reg.sp + msl_pkg::RTI_POP;
						if (s_next.run_pc >= msl_pkg::FLASH_BASE && !s_reg.sec_ok)
							s_next.ill_rst = 1'b1;
						else
							s_next.run_go = 1'b1;
						s_next.st = S_RUN;
					end
				endcase
			end
			S_RET: if (!s_reg.tx_on) begin
				tx_req = 1'b1;
				tx_d = s_reg.ret[15:8];
				s_next.ret = {s_reg.ret[7:0], 8'h00};
				s_next.retn = s_reg.retn - 2'h1;
				if (s_reg.retn == 2'h1)
					s_next.st = S_OP;
			end
			S_BRK: if (!s_reg.tx_on) begin
				tx_req = 1'b1;
				tx_brk = 1'b1;
				s_next.st = S_OP;
			end
			S_RUN: begin
			end
			default: s_next.st = S_INIT;
		endcase

		// transmitter: two driven-high slots, then ten frame slots
		if (!s_reg.tx_on) begin
			s_next.pin_oe = 1'b0;
			if (tx_req) begin
				s_next.tx_on = 1'b1;
				s_next.tx_n = '0;
				s_next.tx_t = s_reg.bit_cyc - 12'h001;
				s_next.tx_sh = tx_brk ? 12'h003 : {1'b1, tx_d, 3'b011};
				s_next.pin_oe = 1'b1;
				s_next.pin_o = 1'b1;
			end
		end else if (s_reg.tx_t == '0) begin
			if (s_reg.tx_n == 4'(msl_pkg::TX_SLOTS - 1)) begin
				s_next.tx_on = 1'b0;
				s_next.pin_oe = 1'b0;
			end else begin
				s_next.tx_n = s_reg.tx_n + 4'h1;
				s_next.tx_sh = s_reg.tx_sh >> 1;
				s_next.pin_o = s_reg.tx_sh[1];
				s_next.tx_t = s_reg.bit_cyc - 12'h001;
			end
		end else begin
			s_next.tx_t = s_reg.tx_t - 12'h001;
		end

		if (mass_erase)
			s_next.code = {msl_pkg::SEC_BYTES{msl_pkg::ERASED}};
		if (warm_rst) begin
			s_next.st = S_SECB;
			s_next.sec_bad = 1'b1;
			s_next.rx_on = 1'b0;
			s_next.tx_on = 1'b0;
			s_next.pin_oe = 1'b0;
			s_next.sp = msl_pkg::SP_RST;
		end
	end

	// ****************
	// registers
	// ****************
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			s_reg <= '0;
			s_reg.st <= S_INIT;
			s_reg.sync <= 3'h7;
			s_reg.rxv <= 1'b1;
			s_reg.rxv_d <= 1'b1;
			s_reg.pin_o <= 1'b1;
			s_reg.bit_cyc <= 12'(BIT_DIV * msl_pkg::DIV_FORCED);
			s_reg.code <= msl_pkg::SEC_CODE_RST;
			s_reg.sp <= msl_pkg::SP_RST;
		end else begin
			s_reg <= s_next;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (mem_we)
			mem[mem_a[MEM_AW-1:0]] <= mem_d;
	end

	assign link.dev_o = s_reg.pin_o;
	assign link.dev_oe = s_reg.pin_oe;
	assign sec_ok = s_reg.sec_ok;
	assign run_go = s_reg.run_go;
	assign run_pc = s_reg.run_pc;
	assign index_hi = s_reg.idx_hi;
	assign illegal_addr_rst = s_reg.ill_rst;

endmodule : msl_dev

// *** msl_pkg.sv ***
/*
 * shared constants of the monitor serial command link.
 * assumes both ends run on one 200 MHz clock.
 */
package msl_pkg;

	// ****************
	// bit timing
	// ****************
	localparam int BIT_DIV       = 278;
	localparam int DIV_NORM_LO   = 2;
	localparam int DIV_NORM_HI   = 4;
	localparam int DIV_FORCED    = 4;
	localparam int TMR_W         = 12;
	localparam int FRAME_BITS    = 10;
	localparam int TX_SLOTS      = 12;
	localparam int WIN_BITS      = 11;
	localparam int GAP_BITS      = 1;
	localparam int ECHO_TMO_BITS = 20;
	localparam int STRAP_WAIT    = 3;

	// ****************
	// commands
	// ****************
	localparam logic [7:0] CMD_READ   = 8'h01;
	localparam logic [7:0] CMD_WRITE  = 8'h02;
	localparam logic [7:0] CMD_INDEXED_READ_CMD  = 8'h03;
	localparam logic [7:0] CMD_INDEXED_WRITE_CMD = 8'h04;
	localparam logic [7:0] CMD_SPREAD = 8'h05;
	localparam logic [7:0] CMD_RUN    = 8'h06;

	// ****************
	// memory map and security
	// ****************
	localparam int          SEC_BYTES     = 8;
	localparam logic [63:0] SEC_CODE_RST  = 64'h0123_4567_89ab_cdef;
	localparam logic [7:0]  ERASED        = 8'hff;
	localparam logic [15:0] RAM_STAT_ADDR = 16'h0040;
	localparam int          RAM_STAT_BIT  = 6;
	localparam logic [15:0] FLASH_BASE    = 16'h8000;
	localparam logic [7:0]  INVALID_DATA  = 8'h00;
	localparam logic [15:0] SP_RST        = 16'h00f9;
	localparam logic [15:0] PC_HI_OFS     = 16'h0005;
	localparam logic [15:0] PC_LO_OFS     = 16'h0006;
	localparam logic [15:0] RTI_POP       = 16'h0006;

endpackage : msl_pkg

// *** msl_link_if.sv ***
/*
 * single-wire serial link between monitor device and host.
 * assumes a pullup: the wire is high unless an enabled end drives low.
 */
interface msl_link_if;
	logic dev_o;
	logic dev_oe;
	logic host_o;
	logic host_oe;
	logic line;

	assign line = (~dev_oe | dev_o) & (~host_oe | host_o);

	modport dev (output dev_o, output dev_oe, input line);
	modport host (output host_o, output host_oe, input line);
endinterface : msl_link_if

// *** msl_host.sv ***
/*
 * programming host end of the monitor serial link.
 * assumes the device bit period equals BIT_CYC clocks.
 */
module msl_host #(
	parameter int BIT_CYC      = msl_pkg::BIT_DIV * msl_pkg::DIV_FORCED,
	parameter int ECHO_TMO_CYC = msl_pkg::ECHO_TMO_BITS * BIT_CYC,
	parameter int W            = 9,
	parameter int DEPTH        = 2
) (
	// clock and reset
	input  wire logic         sys_clk,
	input  wire logic         rst,
	// link
	msl_link_if.host          link,
	// bytes to send, bit 8 asks for a break
	input  wire logic         tx_valid,
	input  wire logic [W-1:0] tx_data,
	output logic              tx_ready,
	// received bytes and breaks
	output logic              rx_valid,
	output logic [7:0]        rx_data,
	output logic              rx_brk
);
	localparam int PW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);

	typedef enum logic [1:0] {H_IDLE, H_SEND, H_ECHO, H_GAP} msl_host_st_e;

	typedef struct packed {
		msl_host_st_e          st;
		logic [2:0]            sync;
		logic                  rxv;
		logic                  rxv_d;
		logic                  rx_on;
		logic [3:0]            rx_n;
		logic [15:0]           rx_t;
		logic [9:0]            rx_sh;
		logic [3:0]            tx_n;
		logic [9:0]            tx_sh;
		logic [23:0]           t;
		logic                  pin_o;
		logic                  pin_oe;
		logic [DEPTH-1:0][W-1:0] buf_d;
		logic [PW-1:0]         wp;
		logic [PW-1:0]         rp;
		logic [CW-1:0]         cnt;
		logic                  rdy;
		logic                  rx_valid;
		logic [7:0]            rx_data;
		logic                  rx_brk;
	} msl_host_s;

	msl_host_s s_reg;
	msl_host_s s_next;
	logic      push;
	logic      pop;
	logic      got;
	logic [W-1:0] head;

	// ****************
	// next state
	// ****************
	always_comb begin
		s_next = s_reg;
		s_next.rx_valid = 1'b0;
		s_next.rx_brk = 1'b0;
		push = tx_valid && s_reg.rdy;
		pop = 1'b0;
		got = 1'b0;
		head = s_reg.buf_d[s_reg.rp];

		// receiver
		s_next.sync = {s_reg.sync[1:0], link.line};
		if (s_reg.sync[1] == s_reg.sync[2])
			s_next.rxv = s_reg.sync[2];
		s_next.rxv_d = s_reg.rxv;
		if (s_reg.st == H_SEND) begin
			s_next.rx_on = 1'b0;
		end else if (!s_reg.rx_on) begin
			if (s_reg.rxv_d && !s_reg.rxv) begin
				s_next.rx_on = 1'b1;
				s_next.rx_n = '0;
				s_next.rx_t = 16'(BIT_CYC / 2);
			end
		end else if (s_reg.rx_t == '0) begin
			s_next.rx_sh = {s_reg.rxv, s_reg.rx_sh[9:1]};
			s_next.rx_t = 16'(BIT_CYC - 1);
			s_next.rx_n = s_reg.rx_n + 4'h1;
			if (s_reg.rx_n == 4'(msl_pkg::FRAME_BITS - 1)) begin
				s_next.rx_on = 1'b0;
				s_next.rx_valid = s_reg.rxv;
				s_next.rx_data = s_next.rx_sh[8:1];
				s_next.rx_brk = !s_reg.rxv && s_reg.rx_sh[9:1] == '0;
				got = 1'b1;
			end
		end else begin
			s_next.rx_t = s_reg.rx_t - 16'h0001;
		end

		// sender: one frame, wait echo, then a gap
		case (s_reg.st)
			H_IDLE: if (s_reg.cnt != '0) begin
				pop = 1'b1;
				s_next.st = H_SEND;
				s_next.tx_sh = head[8] ? 10'h000 : {1'b1, head[7:0], 1'b0};
				s_next.tx_n = '0;
				s_next.t = 24'(BIT_CYC - 1);
				s_next.pin_oe = 1'b1;
				s_next.pin_o = 1'b0;
			end
			H_SEND: if (s_reg.t == '0) begin
				s_next.t = 24'(BIT_CYC - 1);
				s_next.tx_n = s_reg.tx_n + 4'h1;
				s_next.tx_sh = s_reg.tx_sh >> 1;
				s_next.pin_o = s_reg.tx_sh[1];
				if (s_reg.tx_n == 4'(msl_pkg::FRAME_BITS - 1)) begin
					s_next.pin_oe = 1'b0;
					s_next.pin_o = 1'b1;
					s_next.st = H_ECHO;
					s_next.t = 24'(ECHO_TMO_CYC);
				end
			end else begin
				s_next.t = s_reg.t - 24'h000001;
			end
			H_ECHO: if (got || s_reg.t == '0) begin
				s_next.st = H_GAP;
				s_next.t = 24'(msl_pkg::GAP_BITS * BIT_CYC);
			end else begin
				s_next.t = s_reg.t - 24'h000001;
			end
			H_GAP: if (s_reg.t == '0)
				s_next.st = H_IDLE;
			else
				s_next.t = s_reg.t - 24'h000001;
			default: s_next.st = H_IDLE;
		endcase

		// two-entry buffer
		if (push) begin
			s_next.buf_d[s_reg.wp] = tx_data;
			s_next.wp = (s_reg.wp == PW'(DEPTH - 1)) ? '0 : s_reg.wp + 1'b1;
		end
		if (pop)
			s_next.rp = (s_reg.rp == PW'(DEPTH - 1)) ? '0 : s_reg.rp + 1'b1;
		s_next.cnt = s_reg.cnt + CW'(push) - CW'(pop);
		s_next.rdy = s_next.cnt != CW'(DEPTH);
	end

	// ****************
	// registers
	// ****************
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			s_reg <= '0;
			s_reg.st <= H_IDLE;
			s_reg.sync <= 3'h7;
			s_reg.rxv <= 1'b1;
			s_reg.rxv_d <= 1'b1;
			s_reg.pin_o <= 1'b1;
			s_reg.rdy <= 1'b1;
		end else begin
			s_reg <= s_next;
		end
	end

	assign link.host_o = s_reg.pin_o;
	assign link.host_oe = s_reg.pin_oe;
	assign tx_ready = s_reg.rdy;
	assign rx_valid = s_reg.rx_valid;
	assign rx_data = s_reg.rx_data;
	assign rx_brk = s_reg.rx_brk;

endmodule : msl_host

// *** msl_link_chk.sv ***
/*
 * checker of the serial wire between device and host ends.
 * assumes both ends share sys_clk and one bit period of BIT_CYC clocks.
 */
module msl_link_chk #(
	parameter int BIT_CYC = 556
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// link wires
	input wire logic dev_o,
	input wire logic dev_oe,
	input wire logic host_o,
	input wire logic host_oe,
	input wire logic line
);
	// ****************
	// helper counters
	// ****************
	logic [15:0] dev_cnt_reg;
	logic [15:0] host_cnt_reg;
	logic [15:0] stop_cnt_reg;
	logic [3:0]  frames_reg;

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			dev_cnt_reg  <= 16'h0000;
			host_cnt_reg <= 16'h0000;
			stop_cnt_reg <= 16'hffff;
			frames_reg   <= 4'h0;
		end else begin
			dev_cnt_reg  <= dev_oe ? dev_cnt_reg + 16'h0001 : 16'h0000;
			host_cnt_reg <= host_oe ? host_cnt_reg + 16'h0001 : 16'h0000;
			if (dev_oe && dev_cnt_reg == 16'(11 * BIT_CYC))
				stop_cnt_reg <= 16'h0000;
			else if (stop_cnt_reg != 16'hffff)
				stop_cnt_reg <= stop_cnt_reg + 16'h0001;
			if ($fell(host_oe) && frames_reg != 4'hf)
				frames_reg <= frames_reg + 4'h1;
		end
	end

	// ****************
	// assertions
	// ****************
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	property p_pre_high;
		dev_oe && dev_cnt_reg < 16'(2 * BIT_CYC) |-> dev_o;
	endproperty
	a_pre_high: assert property (p_pre_high) else $error("device lead-in not high");

	property p_dev_start;
		dev_oe && dev_cnt_reg == 16'(2 * BIT_CYC) |-> !dev_o;
	endproperty
	a_dev_start: assert property (p_dev_start) else $error("device start bit not low");

	property p_dev_len;
		$fell(dev_oe) |-> dev_cnt_reg == 16'(12 * BIT_CYC);
	endproperty
	a_dev_len: assert property (p_dev_len) else $error("device drive length wrong");

	property p_dev_grid;
		dev_oe && $past(dev_oe) && (dev_o != $past(dev_o)) |-> (dev_cnt_reg % BIT_CYC) == 0;
	endproperty
	a_dev_grid: assert property (p_dev_grid) else $error("device bit edge off grid");

	property p_host_start;
		$rose(host_oe) |-> !host_o;
	endproperty
	a_host_start: assert property (p_host_start) else $error("host start bit not low");

	property p_host_len;
		$fell(host_oe) |-> host_cnt_reg == 16'(10 * BIT_CYC);
	endproperty
	a_host_len: assert property (p_host_len) else $error("host frame length wrong");

	property p_host_gap;
		$rose(host_oe) |-> stop_cnt_reg >= 16'(BIT_CYC);
	endproperty
	a_host_gap: assert property (p_host_gap) else $error("host sent too soon after echo");

	property p_brk_late;
		dev_oe && dev_cnt_reg == 16'(11 * BIT_CYC) && !dev_o |-> frames_reg >= 4'h8;
	endproperty
	a_brk_late: assert property (p_brk_late) else $error("device break before eight bytes");

	property p_half_duplex;
		!(dev_oe && host_oe);
	endproperty
	a_half_duplex: assert property (p_half_duplex) else $error("both ends drive the wire");

	c_dev_brk: cover property (dev_oe && dev_cnt_reg == 16'(11 * BIT_CYC) && !dev_o);
	c_host_frame: cover property ($fell(host_oe));
	c_dev_frame: cover property ($fell(dev_oe) && line);
endmodule : msl_link_chk

// *** testbench.sv ***
/*
 * testbench joining device and host ends over the serial link.
 * assumes test voltage high and divide select low: bit is 16 clocks.
 */
module testbench;
	timeunit 1ns;
	timeprecision 1ps;

	localparam int DIV   = 8;
	localparam int BIT   = DIV * msl_pkg::DIV_NORM_LO;
	localparam int WDOG  = 60000;

	logic        sys_clk;
	logic        rst;
	logic        warm_rst;
	logic        test_high_voltage;
	logic        clock_divide_select_pin;
	logic        mass_erase;
	logic        sec_ok;
	logic        run_go;
	logic [15:0] run_pc;
	logic [7:0]  index_hi;
	logic        illegal_addr_rst;
	logic        tx_valid;
	logic [8:0]  tx_data;
	logic        tx_ready;
	logic        rx_valid;
	logic [7:0]  rx_data;
	logic        rx_brk;
	int          n_mismatch;
	int          num_checks;
	int          seed;
	logic [7:0]  got;
	logic [7:0]  got_lo;
	logic        brk;
	logic [15:0] wr_addr;
	logic [7:0]  wr_data;

	// ****************
	// ends and checker
	// ****************
	msl_link_if link();

	msl_dev #(.BIT_DIV(DIV)) i_msl_dev (.sys_clk(sys_clk), .rst(rst), .warm_rst(warm_rst), .link(link),
		.test_high_voltage(test_high_voltage), .clock_divide_select_pin(clock_divide_select_pin),
		.mass_erase(mass_erase), .sec_ok(sec_ok), .run_go(run_go), .run_pc(run_pc),
		.index_hi(index_hi), .illegal_addr_rst(illegal_addr_rst));

	msl_host #(.BIT_CYC(BIT), .ECHO_TMO_CYC(20 * BIT)) i_msl_host (.sys_clk(sys_clk), .rst(rst),
		.link(link), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
		.rx_valid(rx_valid), .rx_data(rx_data), .rx_brk(rx_brk));

	msl_link_chk #(.BIT_CYC(BIT)) i_msl_link_chk (.sys_clk(sys_clk), .rst(rst),
		.dev_o(link.dev_o), .dev_oe(link.dev_oe), .host_o(link.host_o),
		.host_oe(link.host_oe), .line(link.line));

	// ****************
	// expectations
	// ****************
	function automatic logic [7:0] sec_byte(input int n);
		return msl_pkg::SEC_CODE_RST[63 - 8 * n -: 8];
	endfunction : sec_byte

	function automatic logic [15:0] sp_answer();
		return msl_pkg::SP_RST + 16'h0001;
	endfunction : sp_answer

	// ****************
	// tasks
	// ****************
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic finish_test;
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : finish_test

	task automatic send(input logic [8:0] d);
		int k;
		k = $random(seed) & 3;
		repeat (k + 1) @(posedge sys_clk);
		tx_valid <= 1'b1;
		tx_data  <= d;
		forever begin
			@(negedge sys_clk);
			if (tx_ready === 1'b1) break;
		end
		@(posedge sys_clk);
		tx_valid <= 1'b0;
	endtask : send

	task automatic wait_rx(output logic [7:0] d, output logic b);
		int i;
		d = 8'hxx;
		b = 1'bx;
		for (i = 0; i < 40 * BIT; i++) begin
			@(negedge sys_clk);
			if (rx_valid === 1'b1 || rx_brk === 1'b1) begin
				d = rx_data;
				b = rx_brk;
				break;
			end
		end
	endtask : wait_rx

	task automatic xfer(input logic [7:0] d);
		logic [7:0] g;
		logic       b;
		send({1'b0, d});
		wait_rx(g, b);
		check({7'h00, b, g}, {8'h00, d});
	endtask : xfer

	// ****************
	// clock, watchdog
	// ****************
	initial begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end

	initial begin
		#(WDOG * 5);
		n_mismatch++;
		finish_test;
	end

	// ****************
	// main sequence
	// ****************
	initial begin
		seed = 75892;
		n_mismatch = 0;
		num_checks = 0;
		rst = 1'b1;
		warm_rst = 1'b0;
		test_high_voltage = 1'b1;
		clock_divide_select_pin = 1'b0;
		mass_erase = 1'b0;
		tx_valid = 1'b0;
		tx_data = 9'h000;
		repeat (4) @(posedge sys_clk);
		rst <= 1'b0;
		for (int n = 0; n < msl_pkg::SEC_BYTES; n++) xfer(sec_byte(n));
		wait_rx(got, brk);
		check({15'h0000, brk}, 16'h0001);
		check({15'h0000, sec_ok}, 16'h0001);
		$display("test security done");
		xfer(msl_pkg::CMD_READ);
		xfer(msl_pkg::RAM_STAT_ADDR[15:8]);
		xfer(msl_pkg::RAM_STAT_ADDR[7:0]);
		wait_rx(got, brk);
		check({14'h0000, brk, got[msl_pkg::RAM_STAT_BIT]}, 16'h0001);
		$display("test status read done");
		xfer(msl_pkg::CMD_SPREAD);
		wait_rx(got, brk);
		wait_rx(got_lo, brk);
		check({got, got_lo}, sp_answer());
		$display("test stack read done");
		wr_addr = {8'h01, 8'($random(seed))};
		wr_data = 8'($random(seed));
		xfer(msl_pkg::CMD_WRITE);
		xfer(wr_addr[15:8]);
		xfer(wr_addr[7:0]);
		xfer(wr_data);
		repeat (14 * BIT) @(posedge sys_clk);
		xfer(msl_pkg::CMD_READ);
		xfer(wr_addr[15:8]);
		xfer(wr_addr[7:0]);
		wait_rx(got, brk);
		check({7'h00, brk, got}, {8'h00, wr_data});
		$display("test write read done");
		repeat (4 * BIT) @(posedge sys_clk);
		check({15'h0000, link.line}, 16'h0001);
		$display("test idle line done");
		finish_test;
	end
endmodule : testbench
